/* File: ipf_host_model.sv */
// field bus host model issuing one-cycle object requests
`timescale 1ns/100ps
`default_nettype none
module ipf_host_model
(
    // clock
    input  wire logic              clk,
    // object port
    output var ipf_pkg::ipf_req_s  req,
    input  wire ipf_pkg::ipf_rsp_s rsp
);
    initial req = '0;

    // request launched at a falling edge, answer taken one cycle later
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [15:0] wd, output ipf_pkg::ipf_rsp_s r);
        @(negedge clk);
        req = '{rd: !wr, wr: wr, index: idx, subindex: sub, wdata: wd};
        @(negedge clk);
        r = rsp;
        req.rd = 1'b0;
        req.wr = 1'b0;
        req.wdata = ~wd;
    endtask : xfer
endmodule : ipf_host_model
`default_nettype wire

/* File: ipf_input_block.sv */
// general-purpose input block: sync, debounce, pin config and input functions
//
// Notes on behaviour
// - debounced levels word, bit n is input n+1
// - pulse event whenever any debounced level changes
// - config bits 0-7 enable per-input pull-ups
// - config bit 8 selects differential input groups
// - function array per input, sub 0 count
// - codes 0 and 1 do nothing
// - codes 2/3 reset on rise/fall
// - codes 4-7 positive and negative limit switches
// - codes 8/9 motor temperature sensor high/low
// - codes 10/11 disable on level, clear faults
// - codes 12/13 reset on edge, disable on level
// - codes 14/15 home switch high/low
// - codes 16/17 disable only, high/low
// - code 19 switching sync, high-speed inputs only
// - codes 20/21 halt motor, block new trajectory
// - codes 22/23 analog divide while high/low
// - codes 24/25 fast capture, high-speed inputs only
// - code 26 counts rises, upper byte selects
// - another code counts falling edges likewise
// - per-input debounce time in milliseconds
// - raw undebounced levels readable, one per bit
`timescale 1ns/100ps
`default_nettype none
module ipf_input_block
#(
    parameter int          MS_CYC  = ipf_pkg::MS_CYCLES,
    parameter logic [15:0] HS_MASK = 16'h0003
)
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                reset_n,
    // physical input lines
    input  wire logic [15:0]         in_pins,
    // pin conditioning controls
    output logic      [7:0]          pullup_en,
    output logic                     diff_select,
    // object access port
    input  wire ipf_pkg::ipf_req_s   req,
    output ipf_pkg::ipf_rsp_s        rsp,
    // state change event
    output logic                     state_event,
    // input function outputs
    output ipf_pkg::ipf_func_s       func
);
    localparam int N = ipf_pkg::NUM_IN;

    // three-stage synchronisers
    logic [15:0] sync1_ff, sync2_ff, sync3_ff, raw_ff;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_ff <= 16'h0000;
            sync2_ff <= 16'h0000;
            sync3_ff <= 16'h0000;
            raw_ff   <= 16'h0000;
        end
        else
        begin
            sync1_ff <= in_pins;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            raw_ff   <= (sync2_ff & sync3_ff) | (raw_ff & (sync2_ff ^ sync3_ff));
        end
    end

    // millisecond tick
    logic [ipf_pkg::MSDIV_W-1:0] msdiv_ff;
    wire                         ms_tick = (msdiv_ff == ipf_pkg::MSDIV_W'(MS_CYC - 1));
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            msdiv_ff <= '0;
        else if (ms_tick)
            msdiv_ff <= '0;
        else
            msdiv_ff <= msdiv_ff + 1'b1;
    end

    // register access decode
    wire hit_states = (req.index == ipf_pkg::IDX_STATES);
    wire hit_pincfg = (req.index == ipf_pkg::IDX_PINCFG);
    wire hit_func   = (req.index == ipf_pkg::IDX_FUNC);
    wire hit_dbt    = (req.index == ipf_pkg::IDX_DEBOUNCE);
    wire hit_raw    = (req.index == ipf_pkg::IDX_RAW);
    wire sub_zero   = (req.subindex == ipf_pkg::SUB_COUNT);
    wire sub_elem   = !sub_zero && (req.subindex <= 8'(N));
    wire [3:0] elem = 4'(req.subindex - 8'h01);
    wire arr_hit    = (hit_func || hit_dbt) && (sub_zero || sub_elem);
    wire flat_hit   = (hit_states || hit_pincfg || hit_raw) && sub_zero;
    wire map_hit    = arr_hit || flat_hit;
    wire wr_ok      = req.wr && ((hit_pincfg && sub_zero) || ((hit_func || hit_dbt) && sub_elem));
    wire rd_ok      = req.rd && map_hit;
    wire func_we    = req.wr && hit_func && sub_elem;
    wire dbt_we     = req.wr && hit_dbt && sub_elem;

    logic [15:0]      func_rd, dbt_rd;
    logic [N*16-1:0]  func_words, dbt_words;

    ipf_word_mem u_func_mem
    (
        .clk     (clk),
        .reset_n (reset_n),
        .wr_en   (func_we),
        .wr_addr (elem),
        .wr_data (req.wdata),
        .rd_addr (elem),
        .rd_data (func_rd),
        .words   (func_words)
    );

    ipf_word_mem u_dbt_mem
    (
        .clk     (clk),
        .reset_n (reset_n),
        .wr_en   (dbt_we),
        .wr_addr (elem),
        .wr_data (req.wdata),
        .rd_addr (elem),
        .rd_data (dbt_rd),
        .words   (dbt_words)
    );

    // pin configuration register
    logic [15:0] pincfg_ff;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pincfg_ff <= ipf_pkg::PINCFG_RST;
        else if (req.wr && hit_pincfg && sub_zero)
            pincfg_ff <= req.wdata & ipf_pkg::PINCFG_MASK;
    end
    assign pullup_en   = pincfg_ff[ipf_pkg::PULLUP_LSB +: ipf_pkg::PULLUP_W];
    assign diff_select = pincfg_ff[ipf_pkg::DIFF_BIT];

    // debounce per input
    logic [15:0] deb_ff, deb_prev_ff, raw_prev_ff;
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_deb
            logic [ipf_pkg::DBT_W-1:0] cnt_ff;
            logic                      lvl_ff;
            wire  [ipf_pkg::DBT_W-1:0] limit = dbt_words[g*16 +: ipf_pkg::DBT_W];
            wire                       differ = raw_ff[g] ^ deb_ff[g];
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    cnt_ff <= '0;
                    lvl_ff <= 1'b0;
                end
                else if (!differ)
                    cnt_ff <= '0;
                else if (cnt_ff >= limit)
                begin
                    cnt_ff <= '0;
                    lvl_ff <= raw_ff[g];
                end
                else if (ms_tick)
                    cnt_ff <= cnt_ff + 1'b1;
            end
            assign deb_ff[g] = lvl_ff;
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            deb_prev_ff <= 16'h0000;
            raw_prev_ff <= 16'h0000;
        end
        else
        begin
            deb_prev_ff <= deb_ff;
            raw_prev_ff <= raw_ff;
        end
    end
    assign state_event = |(deb_ff ^ deb_prev_ff);

    // per-input function decode
    logic [N-1:0] m_reset, m_clear, m_dis, m_plim, m_nlim, m_temp, m_home;
    logic [N-1:0] m_pwm, m_halt, m_adiv, m_capt, m_cnt;
    generate
        for (g = 0; g < N; g++)
        begin : g_fn
            wire [7:0] code   = func_words[g*16 +: 8];
            wire       pol_lo = code[0];
            wire       act    = deb_ff[g] ^ pol_lo;
            wire       act_p  = deb_prev_ff[g] ^ pol_lo;
            wire       edge_a = act && !act_p;
            wire       fast_e = (raw_ff[g] ^ pol_lo) && !(raw_prev_ff[g] ^ pol_lo);
            wire       hs     = HS_MASK[g];
            // codes 0, 1, 18 and unlisted values match nothing below
            assign m_reset[g] = edge_a && (ipf_pkg::code_in(code, ipf_pkg::FC_RESET_R)
                              || ipf_pkg::code_in(code, ipf_pkg::FC_RSTDIS_H));
            assign m_clear[g] = edge_a && ipf_pkg::code_in(code, ipf_pkg::FC_DISCLR_H);
            assign m_dis[g]   = act && (ipf_pkg::code_in(code, ipf_pkg::FC_DISCLR_H)
                              || ipf_pkg::code_in(code, ipf_pkg::FC_RSTDIS_H)
                              || ipf_pkg::code_in(code, ipf_pkg::FC_DIS_H));
            assign m_plim[g]  = act && ipf_pkg::code_in(code, ipf_pkg::FC_PLIM_H);
            assign m_nlim[g]  = act && ipf_pkg::code_in(code, ipf_pkg::FC_NLIM_H);
            assign m_temp[g]  = act && ipf_pkg::code_in(code, ipf_pkg::FC_TEMP_H);
            assign m_home[g]  = act && ipf_pkg::code_in(code, ipf_pkg::FC_HOME_H);
            assign m_pwm[g]   = hs && (code == ipf_pkg::FC_PWMSYNC) && raw_ff[g];
            assign m_halt[g]  = act && ipf_pkg::code_in(code, ipf_pkg::FC_HALT_H);
            assign m_adiv[g]  = act && ipf_pkg::code_in(code, ipf_pkg::FC_ADIV_H);
            assign m_capt[g]  = hs && fast_e && ipf_pkg::code_in(code, ipf_pkg::FC_CAPT_R);
            assign m_cnt[g]   = edge_a && ipf_pkg::code_in(code, ipf_pkg::FC_CNT_R);
        end
    endgenerate

    // lowest counting input wins the select byte in a shared cycle
    logic [7:0] nxt_sel;
    always_comb
    begin
        nxt_sel = 8'h00;
        for (int i = N - 1; i >= 0; i--)
            if (m_cnt[i])
                nxt_sel = func_words[i*16 + ipf_pkg::SEL_LSB +: 8];
    end

    ipf_pkg::ipf_func_s func_ff, nxt_func;
    always_comb
    begin
        nxt_func.reset_req     = |m_reset;
        nxt_func.fault_clear   = |m_clear;
        nxt_func.disable_amp   = |m_dis;
        nxt_func.pos_limit     = |m_plim;
        nxt_func.neg_limit     = |m_nlim;
        nxt_func.motor_temp    = |m_temp;
        nxt_func.home_switch   = |m_home;
        nxt_func.pwm_sync      = |m_pwm;
        nxt_func.halt_motor    = |m_halt;
        nxt_func.analog_divide = |m_adiv;
        nxt_func.capture       = |m_capt;
        nxt_func.count_pulse   = |m_cnt;
        nxt_func.count_sel     = nxt_sel;
    end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            func_ff <= '0;
        else
            func_ff <= nxt_func;
    end
    assign func = func_ff;

    // read answer, one cycle after the request
    logic        ack_ff, err_ff, arr_sel_ff, sub0_ff, func_sel_ff;
    logic [15:0] flat_ff;
    wire  [15:0] nxt_flat = hit_states ? deb_ff :
                            hit_raw    ? raw_ff :
                            hit_pincfg ? pincfg_ff : 16'h0000;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ack_ff      <= 1'b0;
            err_ff      <= 1'b0;
            arr_sel_ff  <= 1'b0;
            sub0_ff     <= 1'b0;
            func_sel_ff <= 1'b0;
            flat_ff     <= 16'h0000;
        end
        else
        begin
            ack_ff      <= req.rd || req.wr;
            err_ff      <= (req.rd && !rd_ok) || (req.wr && !wr_ok);
            arr_sel_ff  <= arr_hit && sub_elem;
            sub0_ff     <= sub_zero;
            func_sel_ff <= hit_func;
            flat_ff     <= (arr_hit && sub_zero) ? ipf_pkg::NUM_IN_WORD : nxt_flat;
        end
    end
    assign rsp.ack   = ack_ff;
    assign rsp.err   = err_ff;
    assign rsp.rdata = err_ff ? 16'h0000 :
                       !arr_sel_ff ? flat_ff :
                       func_sel_ff ? func_rd : dbt_rd;
endmodule : ipf_input_block
`default_nettype wire

/* File: ipf_input_block_assertions.sv */
// concurrent checks on the object port and pin controls of the input block
`timescale 1ns/100ps
`default_nettype none
module ipf_input_block_assertions
(
    // clock and reset
    input wire logic               clk,
    input wire logic               reset_n,
    // watched ports
    input wire logic [15:0]        in_pins,
    input wire logic [7:0]         pullup_en,
    input wire logic               diff_select,
    input wire ipf_pkg::ipf_req_s  req,
    input wire ipf_pkg::ipf_rsp_s  rsp,
    input wire logic               state_event,
    input wire ipf_pkg::ipf_func_s func
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    wire any_req = req.rd | req.wr;
    wire sub0    = req.subindex == ipf_pkg::SUB_COUNT;
    wire cfg_wr  = req.wr && req.index == ipf_pkg::IDX_PINCFG && sub0;
    wire fn_cnt  = req.index == ipf_pkg::IDX_FUNC && sub0;

    ack_follows_a: assert property (any_req |=> rsp.ack)
        else $error("request without answer");
    ack_caused_a: assert property (rsp.ack |-> $past(any_req))
        else $error("answer without request");
    pullup_set_a: assert property (cfg_wr |=> pullup_en == $past(req.wdata[7:0]))
        else $error("pull-up enables not written");
    diff_set_a: assert property (cfg_wr |=> diff_select == $past(req.wdata[8]))
        else $error("group select not written");
    cfg_hold_a: assert property (!cfg_wr |=> $stable(pullup_en) && $stable(diff_select))
        else $error("pin config changed without write");
    states_ro_a: assert property (req.wr && req.index == ipf_pkg::IDX_STATES |=> rsp.err)
        else $error("write to level word accepted");
    count_read_a: assert property (req.rd && !req.wr && fn_cnt |=>
        !rsp.err && rsp.rdata == ipf_pkg::NUM_IN_WORD)
        else $error("entry count wrong");
    count_wr_a: assert property (req.wr && fn_cnt |=> rsp.err)
        else $error("entry count write accepted");
    reset_pulse_a: assert property (func.reset_req |=> !func.reset_req)
        else $error("reset request longer than one cycle");

    cover property (state_event);
    cover property (func.count_pulse);
    cover property (func.capture);
endmodule : ipf_input_block_assertions

bind ipf_input_block ipf_input_block_assertions u_chk (.clk(clk), .reset_n(reset_n),
    .in_pins(in_pins), .pullup_en(pullup_en), .diff_select(diff_select), .req(req),
    .rsp(rsp), .state_event(state_event), .func(func));
`default_nettype wire

/* File: ipf_input_block_test.sv */
// self-checking testbench of the input block
`timescale 1ns/100ps
`default_nettype none
module ipf_input_block_test;
    logic               clk;
    logic               reset_n;
    logic [15:0]        in_pins;
    logic [7:0]         pullup_en;
    logic               diff_select;
    logic               state_event;
    ipf_pkg::ipf_req_s  req;
    ipf_pkg::ipf_rsp_s  rsp;
    ipf_pkg::ipf_rsp_s  r;
    ipf_pkg::ipf_func_s func;
    logic [3:0]         seen;
    logic [7:0]         sel_seen;
    int                 events;
    int                 mismatches;
    int                 check_count;

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    ipf_input_block #(.MS_CYC(20), .HS_MASK(16'h0003)) u_dut (.clk(clk), .reset_n(reset_n),
        .in_pins(in_pins), .pullup_en(pullup_en), .diff_select(diff_select), .req(req),
        .rsp(rsp), .state_event(state_event), .func(func));
    ipf_host_model u_host (.clk(clk), .req(req), .rsp(rsp));

    // edge pulses are sticky until a scenario clears them
    always @(posedge clk)
    begin
        if (state_event === 1'b1)
            events++;
        seen <= seen | {func.reset_req, func.fault_clear, func.capture, func.count_pulse};
        if (func.count_pulse === 1'b1)
            sel_seen <= func.count_sel;
    end

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [15:0] wd, input logic e, input logic [15:0] exp);
        u_host.xfer(wr, idx, sub, wd, r);
        cmp("ack", 16'h0001, {15'h0000, r.ack});
        cmp("err", {15'h0000, e}, {15'h0000, r.err});
        if (!wr)
            cmp("rdata", exp, r.rdata);
    endtask : acc

    // level outputs a code drives: disable, pos, neg, temp, home, halt, divide
    function automatic logic [6:0] lmask(input logic [7:0] c);
        case (c[7:1])
            7'h02: return 7'h20;
            7'h03: return 7'h10;
            7'h04: return 7'h08;
            7'h05, 7'h06, 7'h08: return 7'h40;
            7'h07: return 7'h04;
            7'h0a: return 7'h02;
            7'h0b: return 7'h01;
            default: return 7'h00;
        endcase
    endfunction : lmask

    // pulse outputs a code drives: reset, fault clear, capture, count
    function automatic logic [3:0] pmask(input logic [7:0] c);
        case (c[7:1])
            7'h01, 7'h06: return 4'h8;
            7'h05: return 4'h4;
            7'h0c: return 4'h2;
            7'h0d: return 4'h1;
            default: return 4'h0;
        endcase
    endfunction : pmask

    function automatic logic [6:0] lv();
        return {func.disable_amp, func.pos_limit, func.neg_limit, func.motor_temp,
                func.home_switch, func.halt_motor, func.analog_divide};
    endfunction : lv

    task automatic t_regs;
        acc(0, ipf_pkg::IDX_PINCFG, 8'h00, 16'h0000, 0, ipf_pkg::PINCFG_RST);
        acc(1, ipf_pkg::IDX_PINCFG, 8'h00, 16'hffa5, 0, 16'h0000);
        cmp("pullup", 16'h00a5, {8'h00, pullup_en});
        cmp("diff", 16'h0001, {15'h0000, diff_select});
        acc(0, ipf_pkg::IDX_PINCFG, 8'h00, 16'h0000, 0, 16'hffa5 & ipf_pkg::PINCFG_MASK);
        acc(1, ipf_pkg::IDX_PINCFG, 8'h00, 16'h005a, 0, 16'h0000);
        cmp("pullup", 16'h005a, {8'h00, pullup_en});
        cmp("diff", 16'h0000, {15'h0000, diff_select});
        acc(1, ipf_pkg::IDX_PINCFG, 8'h01, 16'h0100, 1, 16'h0000);
    endtask : t_regs

    task automatic t_map;
        acc(0, ipf_pkg::IDX_FUNC, 8'h00, 16'h0000, 0, ipf_pkg::NUM_IN_WORD);
        acc(1, ipf_pkg::IDX_FUNC, 8'h00, 16'h0005, 1, 16'h0000);
        acc(1, ipf_pkg::IDX_FUNC, 8'h11, 16'h0005, 1, 16'h0000);
        acc(1, ipf_pkg::IDX_FUNC, 8'h10, 16'h1234, 0, 16'h0000);
        acc(0, ipf_pkg::IDX_FUNC, 8'h10, 16'h0000, 0, 16'h1234);
        acc(1, ipf_pkg::IDX_STATES, 8'h00, 16'hffff, 1, 16'h0000);
        acc(1, ipf_pkg::IDX_RAW, 8'h00, 16'hffff, 1, 16'h0000);
        acc(0, 16'h2193, 8'h00, 16'h0000, 1, 16'h0000);
    endtask : t_map

    task automatic t_debounce;
        acc(1, ipf_pkg::IDX_DEBOUNCE, 8'h02, 16'h0002, 0, 16'h0000);
        in_pins[1] = 1'b1;
        repeat (10) @(negedge clk);
        acc(0, ipf_pkg::IDX_RAW, 8'h00, 16'h0000, 0, 16'h0002);
        acc(0, ipf_pkg::IDX_STATES, 8'h00, 16'h0000, 0, 16'h0000);
        repeat (70) @(negedge clk);
        acc(0, ipf_pkg::IDX_STATES, 8'h00, 16'h0000, 0, 16'h0002);
        in_pins[1] = 1'b0;
        repeat (80) @(negedge clk);
        acc(0, ipf_pkg::IDX_STATES, 8'h00, 16'h0000, 0, 16'h0000);
        cmp("events", 16'h0002, events[15:0]);
    endtask : t_debounce

    task automatic t_funcs;
        logic [6:0] lm;
        logic [3:0] pm;
        for (int c = 0; c < 28; c++)
        begin
            lm = lmask(c[7:0]);
            pm = pmask(c[7:0]);
            acc(1, ipf_pkg::IDX_FUNC, 8'h01, {8'h05, c[7:0]}, 0, 16'h0000);
            seen = 4'h0;
            in_pins[0] = 1'b1;
            repeat (12) @(negedge clk);
            cmp("level_high", c[0] ? 7'h00 : lm, lv());
            cmp("pulse_rise", c[0] ? 4'h0 : pm, seen);
            cmp("pwm_high", {15'h0000, c == 19}, {15'h0000, func.pwm_sync});
            seen = 4'h0;
            in_pins[0] = 1'b0;
            repeat (12) @(negedge clk);
            cmp("level_low", c[0] ? lm : 7'h00, lv());
            cmp("pulse_fall", c[0] ? pm : 4'h0, seen);
            cmp("pwm_low", 16'h0000, {15'h0000, func.pwm_sync});
        end
        cmp("count_sel", 16'h0005, {8'h00, sel_seen});
    endtask : t_funcs

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    initial
    begin
        repeat (8000) @(posedge clk);
        mismatches++;
        give_verdict();
    end

    initial
    begin
        reset_n = 1'b0;
        in_pins = 16'h0000;
        seen = 4'h0;
        sel_seen = 8'h00;
        events = 0;
        mismatches = 0;
        check_count = 0;
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        t_regs();
        t_map();
        t_debounce();
        t_funcs();
        give_verdict();
    end
endmodule : ipf_input_block_test
`default_nettype wire

/* File: ipf_pkg.sv */
// package with register map, function codes and carrier types of the input block
package ipf_pkg;
    localparam int          NUM_IN       = 16;
    localparam logic [15:0] IDX_STATES   = 16'h2190;
    localparam logic [15:0] IDX_PINCFG   = 16'h2191;
    localparam logic [15:0] IDX_FUNC     = 16'h2192;
    localparam logic [15:0] IDX_DEBOUNCE = 16'h2195;
    localparam logic [15:0] IDX_RAW      = 16'h2196;
    localparam logic [7:0]  SUB_COUNT    = 8'h00;
    localparam logic [15:0] NUM_IN_WORD  = 16'h0010;
    localparam logic [15:0] PINCFG_RST   = 16'h0000;
    localparam logic [15:0] PINCFG_MASK  = 16'h01ff;
    localparam int          PULLUP_LSB   = 0;
    localparam int          PULLUP_W     = 8;
    localparam int          DIFF_BIT     = 8;
    localparam int          SEL_LSB      = 8;
    localparam int          MS_NS        = 1000000;
    localparam int          CLK_NS       = 50;
    localparam int          MS_CYCLES    = MS_NS / CLK_NS;
    localparam int          DBT_W        = 14;
    localparam int          MSDIV_W      = 16;

    // function codes live in the low byte of each entry
    localparam logic [7:0] FC_RESET_R  = 8'h02;
    localparam logic [7:0] FC_RESET_F  = 8'h03;
    localparam logic [7:0] FC_PLIM_H   = 8'h04;
    localparam logic [7:0] FC_PLIM_L   = 8'h05;
    localparam logic [7:0] FC_NLIM_H   = 8'h06;
    localparam logic [7:0] FC_NLIM_L   = 8'h07;
    localparam logic [7:0] FC_TEMP_H   = 8'h08;
    localparam logic [7:0] FC_TEMP_L   = 8'h09;
    localparam logic [7:0] FC_DISCLR_H = 8'h0a;
    localparam logic [7:0] FC_DISCLR_L = 8'h0b;
    localparam logic [7:0] FC_RSTDIS_H = 8'h0c;
    localparam logic [7:0] FC_RSTDIS_L = 8'h0d;
    localparam logic [7:0] FC_HOME_H   = 8'h0e;
    localparam logic [7:0] FC_HOME_L   = 8'h0f;
    localparam logic [7:0] FC_DIS_H    = 8'h10;
    localparam logic [7:0] FC_DIS_L    = 8'h11;
    localparam logic [7:0] FC_PWMSYNC  = 8'h13;
    localparam logic [7:0] FC_HALT_H   = 8'h14;
    localparam logic [7:0] FC_HALT_L   = 8'h15;
    localparam logic [7:0] FC_ADIV_H   = 8'h16;
    localparam logic [7:0] FC_ADIV_L   = 8'h17;
    localparam logic [7:0] FC_CAPT_R   = 8'h18;
    localparam logic [7:0] FC_CAPT_F   = 8'h19;
    localparam logic [7:0] FC_CNT_R    = 8'h1a;
    localparam logic [7:0] FC_CNT_F    = 8'h1b;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] index;
        logic [7:0]  subindex;
        logic [15:0] wdata;
    } ipf_req_s;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] rdata;
    } ipf_rsp_s;

    typedef struct packed {
        logic       reset_req;
        logic       fault_clear;
        logic       disable_amp;
        logic       pos_limit;
        logic       neg_limit;
        logic       motor_temp;
        logic       home_switch;
        logic       pwm_sync;
        logic       halt_motor;
        logic       analog_divide;
        logic       capture;
        logic       count_pulse;
        logic [7:0] count_sel;
    } ipf_func_s;

    // two entries per function pair, even code active high or rising
    function automatic logic code_in(input logic [7:0] code, input logic [7:0] base);
        return code[7:1] == base[7:1];
    endfunction : code_in
endpackage : ipf_pkg

/* File: ipf_word_mem.sv */
// small word store with registered read port and a flat view of all words
`timescale 1ns/100ps
`default_nettype none
module ipf_word_mem
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // write port
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    // read port
    input  wire logic [3:0]  rd_addr,
    output logic      [15:0] rd_data,
    // all words for the per-input logic
    output logic      [ipf_pkg::NUM_IN*16-1:0] words
);
    logic [15:0] mem_ff [ipf_pkg::NUM_IN];
    logic [15:0] rd_data_ff;

    genvar g;
    generate
        for (g = 0; g < ipf_pkg::NUM_IN; g++)
        begin : g_word
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    mem_ff[g] <= 16'h0000;
                else if (wr_en && wr_addr == 4'(g))
                    mem_ff[g] <= wr_data;
            end
            assign words[g*16 +: 16] = mem_ff[g];
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rd_data_ff <= 16'h0000;
        else
            rd_data_ff <= mem_ff[rd_addr];
    end
    assign rd_data = rd_data_ff;
endmodule : ipf_word_mem
`default_nettype wire
